// file: cmtd_chk_sva.sv
`timescale 1ns/10ps
module cmtd_chk #(
	parameter int unsigned DAC_W = 10
) (
	input wire logic             clk,
	input wire logic             srst,
	input wire logic             ce,
	input wire logic             wr_en,
	input wire logic [5:0]       addr,
	input wire logic [23:0]      wdata,
	input wire logic             drive_loop_open_pin,
	input wire logic             external_cm_switch,
	input wire logic             reference_cm_switch,
	input wire logic             la_cm_switch,
	input wire logic             ll_cm_switch,
	input wire logic             ra_cm_switch,
	input wire logic             drive_cm_switch,
	input wire logic             common_electrode_mode,
	input wire logic             drive_fault_flag,
	input wire logic [DAC_W-1:0] test_dac_code,
	input wire logic             test_dac_to_channels,
	input wire logic             test_dac_to_pin,
	input wire logic             test_dac_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire limbs = la_cm_switch | ll_cm_switch | ra_cm_switch;
	sequence dac_wr; ce && wr_en && addr == 6'h0A; endsequence
	// a fresh write restarts the count, so the quiet run must be unbroken
	sequence dac_quiet; (ce && !(wr_en && addr == 6'h0A))[*5]; endsequence
	ext_excl_a: assert property (external_cm_switch |->
		!reference_cm_switch && !limbs) else $error("ext not exclusive");
	ref_alone_a: assert property (reference_cm_switch |->
		!limbs && !drive_cm_switch) else $error("ref with electrodes");
	power_off_a: assert property (ce && wr_en && addr == 6'h01 &&
		!wdata[3] |=> !(external_cm_switch | reference_cm_switch | limbs))
		else $error("switch closed while powered down");
	fault_lat_a: assert property ((ce && drive_loop_open_pin)[*5]
		|-> drive_fault_flag) else $error("fault flag missing");
	dac_busy_a: assert property (dac_wr |=> test_dac_busy)
		else $error("no busy after dac write");
	dac_load_a: assert property (dac_wr ##1 dac_quiet |=>
		!test_dac_busy && test_dac_code == $past(wdata[DAC_W-1:0], 6))
		else $error("dac code not loaded");
	dac_route_a: assert property (dac_wr ##0 wdata[15] |=>
		{test_dac_to_pin, test_dac_to_channels} == $past(wdata[14:13]))
		else $error("dac route wrong");
	ce_mode_a: assert property (ce && wr_en && addr == 6'h05 |=>
		common_electrode_mode == $past(wdata[8])) else $error("ce mode");
endmodule : cmtd_chk
bind cmtd_top cmtd_chk #(.DAC_W(DAC_W)) chk_u (.clk(clk), .srst(srst),
	.ce(ce), .wr_en(wr_en), .addr(addr), .wdata(wdata),
	.drive_loop_open_pin(drive_loop_open_pin),
	.external_cm_switch(external_cm_switch),
	.reference_cm_switch(reference_cm_switch),
	.la_cm_switch(la_cm_switch), .ll_cm_switch(ll_cm_switch),
	.ra_cm_switch(ra_cm_switch), .drive_cm_switch(drive_cm_switch),
	.common_electrode_mode(common_electrode_mode),
	.drive_fault_flag(drive_fault_flag), .test_dac_code(test_dac_code),
	.test_dac_to_channels(test_dac_to_channels),
	.test_dac_to_pin(test_dac_to_pin), .test_dac_busy(test_dac_busy));

// file: cmtd_dac_update.sv
`timescale 1ns/10ps
`include "cmtd_regs.svh"
module cmtd_dac_update #(
	parameter int unsigned DAC_W = `CMTD_DAC_W
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             ce,
	input  wire logic             load,
	input  wire logic [DAC_W-1:0] code_in,
	input  wire logic [2:0]       mode_in,
	output logic      [DAC_W-1:0] code_out,
	output logic      [2:0]       mode_out,
	output logic                  busy
);
	import cmtd_pkg::*;
	initial if (DAC_W < 2) $error("DAC_W too small");
	cmtd_dac_state_e  state_r;
	logic [2:0]       cnt_r;
	logic [DAC_W-1:0] pend_code_r;
	logic [2:0]       pend_mode_r;
	// output takes the new word only after the trailing clocks arrive
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r     <= CMTD_DAC_IDLE;
			cnt_r       <= 3'h0;
			pend_code_r <= '0;
			pend_mode_r <= 3'h0;
			code_out    <= '0;
			mode_out    <= 3'h0;
		end else if (ce) begin
			case (state_r)
				CMTD_DAC_IDLE: begin
					if (load) begin
						pend_code_r <= code_in;
						pend_mode_r <= mode_in;
						cnt_r       <= 3'h0;
						state_r     <= CMTD_DAC_WAIT;
					end
				end
				CMTD_DAC_WAIT: begin
					if (load) begin
						pend_code_r <= code_in;
						pend_mode_r <= mode_in;
						cnt_r       <= 3'h0;
					end else if (cnt_r == `CMTD_TRAIL_CLKS - 3'h1) begin
						code_out <= pend_code_r; // RQ13
						mode_out <= pend_mode_r;
						state_r  <= CMTD_DAC_IDLE;
					end else begin
						cnt_r <= cnt_r + 3'h1;
					end
				end
				default: state_r <= CMTD_DAC_IDLE;
			endcase
		end
	end
	assign busy = (state_r == CMTD_DAC_WAIT);
endmodule : cmtd_dac_update

// file: cmtd_host.sv
`timescale 1ns/10ps
module cmtd_host (
	input wire logic clk,
	output logic        wr_en,
	output logic        rd_en,
	output logic [5:0]  addr,
	output logic [23:0] wdata
);
	// bus idles low so nothing is taken before the first access
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr  = 6'h00;
		wdata = 24'h000000;
	end
	task automatic acc(input logic w, input logic [5:0] a,
		input logic [23:0] d);
		@(posedge clk);
		wr_en <= w;
		rd_en <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		// idle bus shows the inverse so stale values cannot pass
		addr <= ~a;
		wdata <= ~d;
		if (w && a == 6'h0A)
			repeat (4) @(posedge clk);
	endtask : acc
endmodule : cmtd_host

// file: cmtd_pkg.sv
package cmtd_pkg;
	typedef enum logic [2:0] {
		CMTD_TONE_DC,
		CMTD_TONE_SINE_10HZ,
		CMTD_TONE_SINE_150HZ,
		CMTD_TONE_SQUARE_1HZ
	} cmtd_tone_e;
	typedef enum {CMTD_DAC_IDLE, CMTD_DAC_WAIT} cmtd_dac_state_e;
endpackage : cmtd_pkg

// file: cmtd_regs.svh
`ifndef CMTD_REGS_SVH
`define CMTD_REGS_SVH
`define CMTD_ADDR_W           6
`define CMTD_DATA_W           24
`define CMTD_OFS_CHAN_CTL     6'h01
`define CMTD_OFS_CM_REF_CTL   6'h05
`define CMTD_OFS_CAL_DAC      6'h0A
`define CMTD_OFS_STATUS       6'h0B
`define CMTD_BIT_PWR_ON       3
`define CMTD_BIT_DRV_CM       23
`define CMTD_BIT_EXT_CM       22
`define CMTD_BIT_LA_CM        21
`define CMTD_BIT_LL_CM        20
`define CMTD_BIT_RA_CM        19
`define CMTD_BIT_CE_EN        8
`define CMTD_BIT_DRV_RDIR_LO  0
`define CMTD_BIT_DAC_CODE_LO  0
`define CMTD_BIT_DAC_MODE_LO  10
`define CMTD_BIT_DAC_RTE_CH   13
`define CMTD_BIT_DAC_RTE_PIN  14
`define CMTD_BIT_DAC_EN       15
`define CMTD_DAC_W            10
`define CMTD_TRAIL_CLKS       3'h4
`define CMTD_RST_24           24'h000000
`endif

// file: cmtd_top.sv
// Function
// RQ1: power bit low opens every common-mode switch regardless of selects.
// RQ2: external switch closed forces reference open, electrode bits ignored.
// RQ3: powered, no external, no electrodes: only reference switch closes.
// RQ4: powered, no external/drive select: each set limb bit closes its switch.
// RQ5: host keeps at least one switch closed when external is open.
// RQ6: reference switch closes only while all electrode switches are open.
// RQ7: open drive loop comparator reported as header fault flag.
// RQ8: drive redirection allowed; fault detection keeps working afterward.
// RQ9: channel enable sits after drive tap; drive reaches any path.
// RQ10: 10-bit test DAC code sets dc level 0.3 V plus scaled 2.4 V.
// RQ11: test tones: 10 Hz or 150 Hz sine, 1 Hz square.
// RQ12: test DAC routes to channel inputs or dedicated pin.
// RQ13: host gives four trailing clocks after a test DAC write.
// RQ14: common electrode enable bit turns common-electrode mode off or on.
// RQ15: switch selects decoded combinationally, external and reference exclusive.
`timescale 1ns/10ps
`include "cmtd_regs.svh"
module cmtd_top #(
	parameter int unsigned DAC_W = `CMTD_DAC_W,
	parameter int unsigned N_PATH = 4
) (
	input  wire logic                    clk,
	input  wire logic                    srst,
	input  wire logic                    ce,
	input  wire logic                    wr_en,
	input  wire logic                    rd_en,
	input  wire logic [`CMTD_ADDR_W-1:0] addr,
	input  wire logic [`CMTD_DATA_W-1:0] wdata,
	output logic      [`CMTD_DATA_W-1:0] rdata,
	input  wire logic                    drive_loop_open_pin,
	output logic                         external_cm_switch,
	output logic                         reference_cm_switch,
	output logic                         la_cm_switch,
	output logic                         ll_cm_switch,
	output logic                         ra_cm_switch,
	output logic                         drive_cm_switch,
	output logic      [N_PATH-1:0]       drive_redirect_switch,
	output logic                         common_electrode_mode,
	output logic                         drive_fault_flag,
	output logic      [DAC_W-1:0]        test_dac_code,
	output cmtd_pkg::cmtd_tone_e         test_dac_tone,
	output logic                         test_dac_to_channels,
	output logic                         test_dac_to_pin,
	output logic                         test_dac_busy
);
	import cmtd_pkg::*;
	initial if (N_PATH < 1 || N_PATH > 8) $error("N_PATH out of range");
	// code field must stay below the mode field of the same word
	initial if (DAC_W < 2 || DAC_W > `CMTD_BIT_DAC_MODE_LO)
		$error("DAC_W out of range");

	logic [`CMTD_DATA_W-1:0] chan_ctl_r;
	logic [`CMTD_DATA_W-1:0] cm_ref_ctl_r;
	logic [`CMTD_DATA_W-1:0] cal_dac_r;
	logic                    loop_s1_r;
	logic                    loop_s2_r;
	logic                    dac_load;
	logic [2:0]              mode_out;
	logic                    pwr;
	logic                    ext;
	logic                    drv;
	logic                    any_limb;

	function automatic logic hit(input logic [`CMTD_ADDR_W-1:0] a,
			input logic [`CMTD_ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	always_ff @(posedge clk) begin
		if (srst) begin
			chan_ctl_r   <= `CMTD_RST_24;
			cm_ref_ctl_r <= `CMTD_RST_24;
			cal_dac_r    <= `CMTD_RST_24;
		end else if (ce && wr_en) begin
			if (hit(addr, `CMTD_OFS_CHAN_CTL))
				chan_ctl_r <= wdata;
			if (hit(addr, `CMTD_OFS_CM_REF_CTL))
				cm_ref_ctl_r <= wdata;
			if (hit(addr, `CMTD_OFS_CAL_DAC))
				cal_dac_r <= wdata;
		end
	end
	assign dac_load = wr_en && hit(addr, `CMTD_OFS_CAL_DAC);

	// comparator lives beside the drive amp, so redirection does not blind it
	always_ff @(posedge clk) begin
		if (srst) begin
			loop_s1_r <= 1'b0;
			loop_s2_r <= 1'b0;
		end else if (ce) begin
			loop_s1_r <= drive_loop_open_pin;
			loop_s2_r <= loop_s1_r;
		end
	end
	always_ff @(posedge clk) begin
		if (srst)
			drive_fault_flag <= 1'b0;
		else if (ce)
			drive_fault_flag <= loop_s2_r; // RQ7 RQ8
	end

	always_ff @(posedge clk) begin
		if (srst)
			rdata <= '0;
		else if (ce && rd_en) begin
			if (hit(addr, `CMTD_OFS_CHAN_CTL))
				rdata <= chan_ctl_r;
			else if (hit(addr, `CMTD_OFS_CM_REF_CTL))
				rdata <= cm_ref_ctl_r;
			else if (hit(addr, `CMTD_OFS_CAL_DAC))
				rdata <= cal_dac_r;
			else if (hit(addr, `CMTD_OFS_STATUS))
				rdata <= {22'h0, test_dac_busy, drive_fault_flag};
			else
				rdata <= '0;
		end
	end

	// decoding is combinational so no write order can close both sources
	assign pwr      = chan_ctl_r[`CMTD_BIT_PWR_ON];
	assign ext      = cm_ref_ctl_r[`CMTD_BIT_EXT_CM];
	assign drv      = cm_ref_ctl_r[`CMTD_BIT_DRV_CM];
	assign any_limb = cm_ref_ctl_r[`CMTD_BIT_LA_CM]
		| cm_ref_ctl_r[`CMTD_BIT_LL_CM] | cm_ref_ctl_r[`CMTD_BIT_RA_CM];
	always_comb begin
		external_cm_switch  = 1'b0;
		reference_cm_switch = 1'b0;
		la_cm_switch        = 1'b0;
		ll_cm_switch        = 1'b0;
		ra_cm_switch        = 1'b0;
		drive_cm_switch     = 1'b0;
		if (!pwr) begin
			external_cm_switch = 1'b0; // RQ1
		end else if (ext) begin
			external_cm_switch = 1'b1; // RQ2 RQ15
		end else if (!any_limb) begin
			reference_cm_switch = 1'b1; // RQ3 RQ6
		end else if (!drv) begin
			la_cm_switch = cm_ref_ctl_r[`CMTD_BIT_LA_CM]; // RQ4
			ll_cm_switch = cm_ref_ctl_r[`CMTD_BIT_LL_CM];
			ra_cm_switch = cm_ref_ctl_r[`CMTD_BIT_RA_CM];
		end else begin
			drive_cm_switch = 1'b1;
		end
	end

	// drive tap precedes each path enable, so any path may carry the drive
	assign drive_redirect_switch = pwr ?
		cm_ref_ctl_r[`CMTD_BIT_DRV_RDIR_LO +: N_PATH] : '0; // RQ9 RQ8
	assign common_electrode_mode = cm_ref_ctl_r[`CMTD_BIT_CE_EN]; // RQ14

	cmtd_dac_update #(
		.DAC_W(DAC_W)
	) u_dac (
		.clk     (clk),
		.srst    (srst),
		.ce      (ce),
		.load    (dac_load),
		.code_in (wdata[`CMTD_BIT_DAC_CODE_LO +: DAC_W]), // RQ10
		.mode_in (wdata[`CMTD_BIT_DAC_MODE_LO +: 3]),
		.code_out(test_dac_code),
		.mode_out(mode_out),
		.busy    (test_dac_busy)
	);
	always_comb begin
		case (mode_out)
			3'h1:    test_dac_tone = CMTD_TONE_SINE_10HZ; // RQ11
			3'h2:    test_dac_tone = CMTD_TONE_SINE_150HZ;
			3'h3:    test_dac_tone = CMTD_TONE_SQUARE_1HZ;
			default: test_dac_tone = CMTD_TONE_DC;
		endcase
	end
	assign test_dac_to_channels = cal_dac_r[`CMTD_BIT_DAC_EN]
		& cal_dac_r[`CMTD_BIT_DAC_RTE_CH]; // RQ12
	assign test_dac_to_pin = cal_dac_r[`CMTD_BIT_DAC_EN]
		& cal_dac_r[`CMTD_BIT_DAC_RTE_PIN];
endmodule : cmtd_top

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
	logic                 clk, srst, ce, pin, rv, obs, ch, tp, cem;
	logic                 wr_en, rd_en, cem_e;
	logic [5:0]           addr, sw_e;
	logic [3:0]           rdir_e;
	wire  [5:0]           sw;
	wire  [3:0]           rdir;
	logic [23:0]          wdata, rdata, r, rq[$];
	logic [9:0]           code;
	logic [14:0]          dac_e;
	logic [25:0]          oq[$];
	cmtd_pkg::cmtd_tone_e tone;
	int                   miscompares = 0;
	int                   comparisons = 0;
	wire  [25:0]          out_v = {rdir, cem, tp, ch, 3'(tone), code, sw};
	cmtd_host host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wdata(wdata));
	cmtd_top dut_u (.clk(clk), .srst(srst), .ce(ce), .wr_en(wr_en),
		.rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
		.drive_loop_open_pin(pin), .external_cm_switch(sw[5]),
		.reference_cm_switch(sw[4]), .la_cm_switch(sw[3]),
		.ll_cm_switch(sw[2]), .ra_cm_switch(sw[1]), .drive_cm_switch(sw[0]),
		.drive_redirect_switch(rdir), .common_electrode_mode(cem),
		.drive_fault_flag(), .test_dac_code(code), .test_dac_tone(tone),
		.test_dac_to_channels(ch), .test_dac_to_pin(tp), .test_dac_busy());
	task automatic cmp_rd(input logic [23:0] got);
		comparisons++;
		if (got !== rq[0]) begin
			miscompares++;
			$display("[FAIL] %0t read %h exp %h", $time, got, rq[0]);
		end
		void'(rq.pop_front());
	endtask : cmp_rd
	task automatic cmp_out(input logic [25:0] got);
		comparisons++;
		if (got !== oq[0]) begin
			miscompares++;
			$display("[FAIL] %0t outputs %h exp %h", $time, got, oq[0]);
		end
		void'(oq.pop_front());
	endtask : cmp_out
	task automatic expect_out(input logic [25:0] e);
		oq.push_back(e);
		obs <= 1'b1;
		@(posedge clk);
		obs <= 1'b0;
	endtask : expect_out
	task automatic complete_run;
		if (rq.size() + oq.size() != 0)
			miscompares++;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	always @(posedge clk) begin
		if (rv)
			cmp_rd(rdata);
		if (obs)
			cmp_out(out_v);
		rv <= ce && rd_en && !srst;
	end
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		complete_run;
	end
	initial begin
		{srst, ce, pin, rv, obs} = 5'h18;
		dac_e = 15'h0000;
		rdir_e = 4'h0;
		void'($urandom(32'h94E9F867));
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 64; i++) begin
			r = $urandom;
			host_u.acc(1'b1, 6'h01, {20'h00000, i[5], 3'h0});
			host_u.acc(1'b1, 6'h05,
				{i[3], i[4], i[2:0], 10'h000, r[4], 4'h0, r[3:0]});
			sw_e = !i[5] ? 6'h00 : i[4] ? 6'h20 : i[2:0] == 0 ? 6'h10 :
				i[3] ? 6'h01 : {2'b00, i[2:0], 1'b0};
			cem_e = r[4];
			rdir_e = i[5] ? r[3:0] : 4'h0;
			expect_out({rdir_e, cem_e, dac_e, sw_e});
		end
		$display("cm selection test done");
		for (int m = 0; m < 8; m++) begin
			r = $urandom;
			host_u.acc(1'b1, 6'h0A,
				{8'h00, 1'b1, r[11:10], m[2:0], r[9:0]});
			@(posedge clk);
			// codes above the last tone fall back to the dc level
			dac_e = {r[11:10], m < 4 ? m[2:0] : 3'h0, r[9:0]};
			expect_out({rdir_e, cem_e, dac_e, sw_e});
		end
		$display("test dac test done");
		for (int f = 1; f >= 0; f--) begin
			pin <= f[0];
			repeat (5) @(posedge clk);
			rq.push_back({23'h000000, f[0]});
			host_u.acc(1'b0, 6'h0B, 24'h000000);
		end
		rq.push_back(24'h000000);
		host_u.acc(1'b0, 6'h3F, 24'h000000);
		repeat (3) @(posedge clk);
		$display("fault and status test done");
		// a write with the clock enable low must leave every output alone
		ce <= 1'b0;
		host_u.acc(1'b1, 6'h01, 24'h000000);
		expect_out({rdir_e, cem_e, dac_e, sw_e});
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		$display("clock enable test done");
		complete_run;
	end
endmodule : testbench
